// ==== dv/rcsw_sw_model.sv ====
// Software-side model that brings up radio clocks and power domain
`timescale 1ns/1ps
module rcsw_sw_model
    import rcsw_pkg::*;
#(
    parameter int SETTLE = 20 // Crystal settle wait, core cycles
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wantUp,
    output rcsw_pwr_t pwrState
);
    int cnt; // Settle counter
    // Clocks first, power only after the crystal has settled
    always @(posedge core_clk) begin
        if (!rst_n || !wantUp) begin
            cnt <= 0;
            pwrState <= '0; // Domain down, clocks gated
        end else begin
            pwrState.radioClkEn <= 1'b1;
            if (cnt < SETTLE) begin
                cnt <= cnt + 1;
            end else begin
                pwrState.radioPowered <= 1'b1;
            end
        end
    end
endmodule // rcsw_sw_model

// ==== dv/rcsw_top_properties.sv ====
// Concurrent checks on the sleep exit and diagnostic port
`timescale 1ns/1ps
module rcsw_top_properties
    import rcsw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire rcsw_pwr_t pwrState,
    input wire rcsw_bb_t bbSignals,
    input wire logic lowpowerWakeInterrupt,
    input wire logic sleepExitInterrupt,
    input wire logic [7:0] diagOut
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] aAddr_ff, nxt_aAddr; // Write address phase capture
    logic aWr_ff, nxt_aWr;
    logic [31:0] s1_ff, s2_ff, s3_ff, nxt_s1, nxt_s2, nxt_s3; // Shadow selects
    logic wakeSeen_ff, nxt_wake; // Wake irq seen since last exit
    logic selA, selB;
    // Shadow the select registers from bus writes
    always_comb begin
        nxt_aWr = hsel && htrans[1] && hready && hwrite;
        nxt_aAddr = haddr[7:0];
        nxt_s1 = (aWr_ff && aAddr_ff == OFS_DIAG_SEL1) ? hwdata : s1_ff;
        nxt_s2 = (aWr_ff && aAddr_ff == OFS_DIAG_SEL2) ? hwdata : s2_ff;
        nxt_s3 = (aWr_ff && aAddr_ff == OFS_DIAG_SEL3) ? hwdata : s3_ff;
        nxt_wake = lowpowerWakeInterrupt | (wakeSeen_ff & !sleepExitInterrupt);
    end
    // Register only
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aWr_ff <= 1'b0;
            aAddr_ff <= 8'h00;
            s1_ff <= 32'h0;
            s2_ff <= 32'h0;
            s3_ff <= 32'h0;
            wakeSeen_ff <= 1'b0;
        end else begin
            aWr_ff <= nxt_aWr;
            aAddr_ff <= nxt_aAddr;
            s1_ff <= nxt_s1;
            s2_ff <= nxt_s2;
            s3_ff <= nxt_s3;
            wakeSeen_ff <= nxt_wake;
        end
    end
    assign selA = s1_ff == DIAG_CTRL_SEL && s2_ff == DIAG_CTRL_SEL && s3_ff == DIAG_ORDER_SEL;
    assign selB = s1_ff == DIAG_DATA_SEL && s2_ff == DIAG_DATA_SEL && s3_ff == DIAG_ORDER_SEL;
    function automatic logic [7:0] mapA(input rcsw_bb_t b);
        return {b.errorIrq, b.rxIrq, b.eventIrq, b.eventActive, b.syncFound & b.syncWindow,
            b.syncWindow, b.rxEn, b.txEn};
    endfunction
    function automatic logic [7:0] mapB(input rcsw_bb_t b);
        return {b.txCoreDataEn, b.txCoreData, b.txDataEn, b.txData, b.rxCoreDataEn,
            b.rxCoreData, b.rxDataEn, b.rxData};
    endfunction
    sequence a_held_s;
        $past(selA);
    endsequence
    sequence b_held_s;
        $past(selB);
    endsequence
    chk_scheme_a_map: assert property (a_held_s |-> diagOut == mapA($past(bbSignals)))
        else $error("diag control scheme mapping wrong");
    chk_scheme_b_map: assert property (b_held_s |-> diagOut == mapB($past(bbSignals)))
        else $error("diag data scheme mapping wrong");
    chk_unknown_low: assert property ($past(!selA && !selB) |-> diagOut == 8'h00)
        else $error("diag not low for unlisted select");
    chk_sync_gated: assert property ($past(selA && !bbSignals.syncWindow) |-> !diagOut[3])
        else $error("sync found outside window");
    chk_error_pin: assert property ($past(selA) && $rose(diagOut[7]) |-> $past(bbSignals.errorIrq))
        else $error("error irq pin without clash");
    chk_event_pins: assert property ($past(selA) |->
        diagOut[6:5] == $past({bbSignals.rxIrq, bbSignals.eventIrq}))
        else $error("event or rx irq pin wrong");
    chk_exit_powered: assert property ($rose(sleepExitInterrupt) |->
        $past(pwrState.radioClkEn && pwrState.radioPowered))
        else $error("sleep exit without clocks and power");
    chk_exit_after_wake: assert property ($rose(sleepExitInterrupt) |-> wakeSeen_ff)
        else $error("sleep exit without wake irq");
endmodule // rcsw_top_properties

// ==== dv/testbench.sv ====
// Self-checking bench for the sleep exit sequencer and diagnostics
`timescale 1ns/1ps
module testbench
    import rcsw_pkg::*;
;
    logic core_clk, rst_n = 0, hsel = 0, hwrite = 0, rdDone = 0, wantUp = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, lastRd;
    logic hreadyout, hresp, wakeIrq, exitIrq;
    logic [7:0] diagOut;
    rcsw_bb_t bb = '0;
    rcsw_pwr_t pwr;
    int nErrors = 0, totalChecks = 0, w, k;
    logic [31:0] expQ[$]; // Expected read data, oldest first
    string nameQ[$];
    logic [31:0] sels [4][3] = '{'{DIAG_CTRL_SEL, DIAG_CTRL_SEL, DIAG_ORDER_SEL},
        '{DIAG_DATA_SEL, DIAG_DATA_SEL, DIAG_ORDER_SEL},
        '{DIAG_DATA_SEL, DIAG_CTRL_SEL, DIAG_ORDER_SEL},
        '{DIAG_CTRL_SEL, DIAG_CTRL_SEL, 32'h7654_3211}};
    rcsw_top rcsw_top_inst (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pwrState(pwr),
        .bbSignals(bb), .lowpowerWakeInterrupt(wakeIrq), .sleepExitInterrupt(exitIrq),
        .diagOut(diagOut));
    rcsw_sw_model rcsw_sw_model_inst (.core_clk(core_clk), .rst_n(rst_n), .wantUp(wantUp),
        .pwrState(pwr));
    // Clock, 8 ns period
    initial begin
        core_clk = 0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Single AHB-Lite transfer; a named read notes its expectation
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input string nm = "");
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        lastRd = hrdata;
        if (!wr && nm != "") begin
            nameQ.push_back(nm);
            expQ.push_back(d);
            rdDone <= 1'b1;
            @(posedge core_clk);
            rdDone <= 1'b0;
        end
    endtask
    // Wait for an irq level, bounded; k gives cycles waited
    task automatic waitOn(input bit ex, input logic lvl);
        for (k = 0; k < 40000; k++) begin
            if ((ex ? exitIrq : wakeIrq) === lvl) break;
            @(posedge core_clk);
        end
        // A wait that runs out is a mismatch, not a silent pass
        check("irq level", {31'h0, (ex ? exitIrq : wakeIrq)}, {31'h0, lvl});
    endtask
    // Port contents that each select set should give; near misses park low
    function automatic logic [7:0] expDiag(input int s, input rcsw_bb_t b);
        if (s == 0) return {b.errorIrq, b.rxIrq, b.eventIrq, b.eventActive,
            b.syncFound & b.syncWindow, b.syncWindow, b.rxEn, b.txEn};
        if (s == 1) return {b.txCoreDataEn, b.txCoreData, b.txDataEn, b.txData,
            b.rxCoreDataEn, b.rxCoreData, b.rxDataEn, b.rxData};
        return 8'h00;
    endfunction
    // Watcher: compare read data against the oldest note
    always @(negedge core_clk) if (rdDone) check(nameQ.pop_front(), hrdata, expQ.pop_front());
    task automatic giveVerdict();
        $display("checks %0d errors %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog sized well past the expected run length
    initial begin
        #700000;
        nErrors++;
        giveVerdict();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        w = $urandom(46);
        bus(0, OFS_SLEEP_DUR, SLEEP_DUR_RST, "dur reset");
        bus(0, OFS_PRESET, PRESET_RST, "preset reset");
        bus(0, OFS_DIAG_SEL3, DIAG_SEL_RST, "sel3 reset");
        bus(0, 8'h3C, 32'h0, "unmapped");
        // Every scheme plus two near misses, random baseband traffic
        for (int i = 0; i < 4; i++) begin
            bus(1, OFS_DIAG_SEL1, sels[i][0]);
            bus(1, OFS_DIAG_SEL2, sels[i][1]);
            bus(1, OFS_DIAG_SEL3, sels[i][2]);
            // Port follows the baseband one edge later; look mid-cycle
            for (int j = 0; j < 40; j++) begin
                @(posedge core_clk);
                bb <= rcsw_bb_t'(16'($urandom));
                @(posedge core_clk);
                @(negedge core_clk);
                check("diag port", {24'h0, diagOut}, {24'h0, expDiag(i, bb)});
            end
        end
        // Scheduled wake: assert lead 2, release lead 1, duration 4
        bus(1, OFS_PRESET, 32'h0002_0102);
        bus(1, OFS_SLEEP_DUR, 32'h4);
        bus(1, OFS_SLEEP_CTRL, 32'h1);
        bus(0, OFS_STATUS, 32'h1, "asleep");
        waitOn(0, 1);
        bus(0, OFS_STATUS, 32'h3, "wake irq early");
        waitOn(0, 0);
        bus(0, OFS_STATUS, 32'h1, "released before expiry");
        repeat (2 * LP_DIV) @(posedge core_clk);
        bus(0, OFS_STATUS, 32'h9, "held for power");
        wantUp <= 1'b1;
        waitOn(1, 1);
        bus(0, OFS_STATUS, 32'h4, "exit");
        bus(0, OFS_ACTUAL, 32'h0);
        check("actual longer", {31'h0, lastRd > 32'h4}, 32'h1);
        bus(1, OFS_STATUS, 32'h4);
        wantUp <= 1'b0;
        // Requested wake, first with the request disabled
        bus(1, OFS_PRESET, 32'h0003_0102);
        bus(1, OFS_SLEEP_DUR, 32'h100);
        bus(1, OFS_SLEEP_CTRL, 32'h3);
        bus(1, OFS_WAKE_REQ, 32'h1);
        repeat (4) @(posedge core_clk);
        bus(0, OFS_STATUS, 32'h1, "request ignored");
        bus(1, OFS_WAKE_REQ, 32'h0);
        bus(1, OFS_SLEEP_CTRL, 32'h1);
        bus(1, OFS_WAKE_REQ, 32'h1);
        repeat (2) @(posedge core_clk);
        bus(0, OFS_STATUS, 32'hB, "request wake irq");
        waitOn(0, 0);
        check("pulse short", {31'h0, k < 2 * LP_DIV}, 32'h1);
        check("pulse long", {31'h0, k > LP_DIV - 20}, 32'h1);
        wantUp <= 1'b1;
        waitOn(1, 1);
        bus(1, OFS_STATUS, 32'h4);
        bus(1, OFS_SLEEP_CTRL, 32'h1);
        bus(0, OFS_STATUS, 32'h0, "entry refused");
        giveVerdict();
    end
endmodule // testbench
bind rcsw_top rcsw_top_properties rcsw_top_properties_inst (.core_clk(core_clk),
    .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .pwrState(pwrState), .bbSignals(bbSignals),
    .lowpowerWakeInterrupt(lowpowerWakeInterrupt), .sleepExitInterrupt(sleepExitInterrupt),
    .diagOut(diagOut));

// ==== verilog/rcsw_pkg.sv ====
// Package with register map, field layout, reset values, timing and types
package rcsw_pkg;
    // Core clock and slow sleep clock rates
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned LP_CLK_HZ = 32_000;
    // Core cycles per slow-clock tick (3906, rounded down)
    localparam int unsigned LP_DIV = CLK_HZ / LP_CLK_HZ;
    localparam int unsigned LP_DIV_W = 12;
    localparam logic [LP_DIV_W-1:0] LP_DIV_LAST = LP_DIV_W'(LP_DIV - 1);

    // Register byte offsets
    localparam logic [7:0] OFS_SLEEP_CTRL = 8'h00; // deep_sleep_control_register
    localparam logic [7:0] OFS_SLEEP_DUR = 8'h04; // sleep_duration
    localparam logic [7:0] OFS_PRESET = 8'h08; // wake_timing_preset_register
    localparam logic [7:0] OFS_ACTUAL = 8'h0C; // actual_sleep_duration_register
    localparam logic [7:0] OFS_WAKE_REQ = 8'h10; // software wake request
    localparam logic [7:0] OFS_STATUS = 8'h14; // state and flags
    localparam logic [7:0] OFS_DIAG_SEL1 = 8'h18; // diag_select_one
    localparam logic [7:0] OFS_DIAG_SEL2 = 8'h1C; // diag_select_two
    localparam logic [7:0] OFS_DIAG_SEL3 = 8'h20; // diag_select_three

    // Field positions
    localparam int unsigned CTRL_SLEEP_ON_BIT = 0;
    localparam int unsigned CTRL_EXT_WAKE_DIS_BIT = 1;
    localparam int unsigned WAKE_REQ_BIT = 0;
    localparam int unsigned STAT_ASLEEP_BIT = 0;
    localparam int unsigned STAT_WAKE_IRQ_BIT = 1;
    localparam int unsigned STAT_EXIT_IRQ_BIT = 2;
    localparam int unsigned STAT_WAIT_UP_BIT = 3;
    localparam int unsigned PRE_ASSERT_LSB = 0;
    localparam int unsigned PRE_RELEASE_LSB = 8;
    localparam int unsigned PRE_EXT_LSB = 16;
    localparam int unsigned PRE_FIELD_W = 8;

    // Reset values
    localparam logic [31:0] SLEEP_DUR_RST = 32'h0000_0040;
    localparam logic [31:0] PRESET_RST = 32'h0002_0110;
    localparam logic [31:0] DIAG_SEL_RST = 32'h0000_0000;

    // Diagnostic scheme select codes
    localparam logic [31:0] DIAG_CTRL_SEL = 32'h8383_8383;
    localparam logic [31:0] DIAG_DATA_SEL = 32'h9292_9292;
    localparam logic [31:0] DIAG_ORDER_SEL = 32'h7654_3210;

    // Internal baseband signals offered to the diagnostic port
    typedef struct packed {
        logic txEn;
        logic rxEn;
        logic syncWindow;
        logic syncFound;
        logic eventActive;
        logic eventIrq;
        logic rxIrq;
        logic errorIrq;
        logic rxData;
        logic rxDataEn;
        logic rxCoreData;
        logic rxCoreDataEn;
        logic txData;
        logic txDataEn;
        logic txCoreData;
        logic txCoreDataEn;
    } rcsw_bb_t;

    // Radio domain state as set up by software
    typedef struct packed {
        logic radioClkEn;
        logic radioPowered;
    } rcsw_pwr_t;

    // Sleep sequencer states
    typedef enum logic [2:0] {
        ST_ACTIVE = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAIT_UP = 3'b100
    } rcsw_state_t;
endpackage

// ==== verilog/rcsw_top.sv ====
// Radio core deep sleep exit sequencer with diagnostic port mux
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// R1: Leave sleep only on expiry or request
// R2: Scheduled wake irq fires assert-lead ticks early
// R3: Handler waits crystal settled, decides exit
// R4: Software enables clocks and powers radio domain
// R5: Expired timer waits for power; duration grows
// R6: Exit and exit irq need expiry, clocks, power; code also exits after an honoured wake request, without expiry
// R7: Wake request raises wake irq at once
// R8: Request pulse length set by pulse field
// R9: No sleep entry while wake request high
// R10: Wake disable bit ignores wake request
// R11: Late request runs both handlers sequentially
// R12: Eight fixed diagnostic outputs
// R13: Three select registers choose diagnostic scheme
// R14: Control scheme maps radio and event signals
// R15: Data scheme maps rx/tx bits and qualifiers
// R16: Sync found only inside sync window
// R17: Error irq on shared memory clash
// R18: Event irq and rx irq pulses
// R19: Wake irq released release-lead ticks early
// R20: Sleep duration at least assert lead plus one
// R21: Unknown select codes drive outputs low
module rcsw_top
    import rcsw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Radio domain state and baseband signals
    input wire rcsw_pwr_t pwrState,
    input wire rcsw_bb_t bbSignals,
    // Interrupts and diagnostics
    output logic lowpowerWakeInterrupt,
    output logic sleepExitInterrupt,
    output logic [7:0] diagOut
);

    // Slow clock divider state
    logic [LP_DIV_W-1:0] lpDiv_ff, nxt_lpDiv;
    logic lpTick; // One-cycle slow-clock enable

    // Bus data phase capture
    logic wrPend_ff, nxt_wrPend;
    logic [7:0] wrAddr_ff, nxt_wrAddr;
    logic [31:0] hrdata_ff, nxt_hrdata;

    // Software registers
    logic extWakeDis_ff, nxt_extWakeDis;
    logic [31:0] sleepDur_ff, nxt_sleepDur;
    logic [31:0] preset_ff, nxt_preset;
    logic [31:0] actualDur_ff, nxt_actualDur;
    logic wakeReq_ff, nxt_wakeReq;
    logic [31:0] diagSel1_ff, nxt_diagSel1;
    logic [31:0] diagSel2_ff, nxt_diagSel2;
    logic [31:0] diagSel3_ff, nxt_diagSel3;

    // Sequencer state
    rcsw_state_t state_ff, nxt_state;
    logic [31:0] sleepCnt_ff, nxt_sleepCnt;
    logic [PRE_FIELD_W-1:0] extCnt_ff, nxt_extCnt;
    logic wakeIrq_ff, nxt_wakeIrq;
    logic exitIrq_ff, nxt_exitIrq;
    logic [7:0] diag_ff, nxt_diag;

    // Decoded write strobes
    logic addrPhase;
    logic wrCtrl, wrWakeReq, wrStatus;
    logic sleepOnReq;

    // Preset fields
    logic [PRE_FIELD_W-1:0] assertLead, releaseLead, extLen;
    logic [31:0] remaining;
    logic inWakeWindow;
    logic reqWake;

    assign assertLead = preset_ff[PRE_ASSERT_LSB +: PRE_FIELD_W];
    assign releaseLead = preset_ff[PRE_RELEASE_LSB +: PRE_FIELD_W];
    assign extLen = preset_ff[PRE_EXT_LSB +: PRE_FIELD_W];

    // Divider: sleep logic advances once per slow-clock period
    always_comb begin
        lpTick = (lpDiv_ff == LP_DIV_LAST);
        nxt_lpDiv = lpTick ? '0 : lpDiv_ff + 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lpDiv_ff <= '0;
        end else begin
            lpDiv_ff <= nxt_lpDiv;
        end
    end

    // Zero-wait slave; every response OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign addrPhase = hsel && htrans[1] && hready;
    assign wrCtrl = wrPend_ff && (wrAddr_ff == OFS_SLEEP_CTRL);
    assign wrWakeReq = wrPend_ff && (wrAddr_ff == OFS_WAKE_REQ);
    assign wrStatus = wrPend_ff && (wrAddr_ff == OFS_STATUS);
    assign sleepOnReq = wrCtrl && hwdata[CTRL_SLEEP_ON_BIT];

    // Bus capture, register writes and read data
    always_comb begin
        nxt_wrPend = addrPhase && hwrite;
        nxt_wrAddr = addrPhase ? haddr[7:0] : wrAddr_ff;
        nxt_extWakeDis = extWakeDis_ff;
        nxt_sleepDur = sleepDur_ff;
        nxt_preset = preset_ff;
        nxt_wakeReq = wakeReq_ff;
        nxt_diagSel1 = diagSel1_ff;
        nxt_diagSel2 = diagSel2_ff;
        nxt_diagSel3 = diagSel3_ff;
        // Writes land at the end of the data phase
        if (wrCtrl) begin
            nxt_extWakeDis = hwdata[CTRL_EXT_WAKE_DIS_BIT];
        end else if (wrAddr_ff == OFS_SLEEP_DUR && wrPend_ff) begin
            nxt_sleepDur = hwdata;
        end else if (wrAddr_ff == OFS_PRESET && wrPend_ff) begin
            nxt_preset = hwdata;
        end else if (wrWakeReq) begin
            nxt_wakeReq = hwdata[WAKE_REQ_BIT];
        end else if (wrAddr_ff == OFS_DIAG_SEL1 && wrPend_ff) begin
            nxt_diagSel1 = hwdata;
        end else if (wrAddr_ff == OFS_DIAG_SEL2 && wrPend_ff) begin
            nxt_diagSel2 = hwdata;
        end else if (wrAddr_ff == OFS_DIAG_SEL3 && wrPend_ff) begin
            nxt_diagSel3 = hwdata;
        end
        // Read data sampled at the address phase; unmapped reads zero
        nxt_hrdata = hrdata_ff;
        if (addrPhase && !hwrite) begin
            nxt_hrdata = '0;
            if (haddr[7:0] == OFS_SLEEP_CTRL) begin
                nxt_hrdata[CTRL_SLEEP_ON_BIT] = (state_ff != ST_ACTIVE);
                nxt_hrdata[CTRL_EXT_WAKE_DIS_BIT] = extWakeDis_ff;
            end else if (haddr[7:0] == OFS_SLEEP_DUR) begin
                nxt_hrdata = sleepDur_ff;
            end else if (haddr[7:0] == OFS_PRESET) begin
                nxt_hrdata = preset_ff;
            end else if (haddr[7:0] == OFS_ACTUAL) begin
                nxt_hrdata = actualDur_ff;
            end else if (haddr[7:0] == OFS_WAKE_REQ) begin
                nxt_hrdata[WAKE_REQ_BIT] = wakeReq_ff;
            end else if (haddr[7:0] == OFS_STATUS) begin
                nxt_hrdata[STAT_ASLEEP_BIT] = (state_ff != ST_ACTIVE);
                nxt_hrdata[STAT_WAKE_IRQ_BIT] = wakeIrq_ff;
                nxt_hrdata[STAT_EXIT_IRQ_BIT] = exitIrq_ff;
                nxt_hrdata[STAT_WAIT_UP_BIT] = (state_ff == ST_WAIT_UP);
            end else if (haddr[7:0] == OFS_DIAG_SEL1) begin
                nxt_hrdata = diagSel1_ff;
            end else if (haddr[7:0] == OFS_DIAG_SEL2) begin
                nxt_hrdata = diagSel2_ff;
            end else if (haddr[7:0] == OFS_DIAG_SEL3) begin
                nxt_hrdata = diagSel3_ff;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 8'h00;
            hrdata_ff <= 32'h0000_0000;
            extWakeDis_ff <= 1'b0;
            sleepDur_ff <= SLEEP_DUR_RST;
            preset_ff <= PRESET_RST;
            wakeReq_ff <= 1'b0;
            diagSel1_ff <= DIAG_SEL_RST;
            diagSel2_ff <= DIAG_SEL_RST;
            diagSel3_ff <= DIAG_SEL_RST;
        end else begin
            wrPend_ff <= nxt_wrPend;
            wrAddr_ff <= nxt_wrAddr;
            hrdata_ff <= nxt_hrdata;
            extWakeDis_ff <= nxt_extWakeDis;
            sleepDur_ff <= nxt_sleepDur;
            preset_ff <= nxt_preset;
            wakeReq_ff <= nxt_wakeReq;
            diagSel1_ff <= nxt_diagSel1;
            diagSel2_ff <= nxt_diagSel2;
            diagSel3_ff <= nxt_diagSel3;
        end
    end

    // Ticks left before the programmed sleep time runs out
    assign remaining = (sleepCnt_ff < sleepDur_ff) ? sleepDur_ff - sleepCnt_ff : '0;
    // Scheduled wake window: on at assert lead, off at release lead
    assign inWakeWindow = (remaining <= {24'h00_0000, assertLead}) // R2
                       && (remaining > {24'h00_0000, releaseLead}); // R19
    // Request only honoured when not disabled
    assign reqWake = wakeReq_ff && !extWakeDis_ff; // R10

    // Sleep sequencer: entry, timing, wake irq and exit
    always_comb begin
        nxt_state = state_ff;
        nxt_sleepCnt = sleepCnt_ff;
        nxt_extCnt = extCnt_ff;
        nxt_actualDur = actualDur_ff;
        // Status write of one clears exit flag; a new exit still wins
        nxt_exitIrq = exitIrq_ff && !(wrStatus && hwdata[STAT_EXIT_IRQ_BIT]);
        // External wake pulse counts down in slow-clock periods
        if (lpTick && extCnt_ff != '0) begin
            nxt_extCnt = extCnt_ff - 1'b1; // R8
        end
        case (state_ff)
            ST_ACTIVE: begin
                // Held request blocks entry
                if (sleepOnReq && !wakeReq_ff) begin // R9
                    nxt_state = ST_SLEEP;
                    nxt_sleepCnt = '0;
                end
            end
            ST_SLEEP: begin
                if (reqWake) begin
                    // Timer keeps counting; pulse width is pulse field less release lead
                    nxt_state = ST_WAIT_UP; // R1
                    nxt_extCnt = (extLen > releaseLead) ? extLen - releaseLead : 8'h01; // R7
                end else if (lpTick) begin
                    nxt_sleepCnt = sleepCnt_ff + 1'b1;
                    if (sleepCnt_ff + 1'b1 >= sleepDur_ff) begin
                        nxt_state = ST_WAIT_UP; // R1
                    end
                end
            end
            ST_WAIT_UP: begin
                // Counting goes on while software brings the domain up
                if (lpTick) begin
                    nxt_sleepCnt = sleepCnt_ff + 1'b1; // R5
                end
                if (pwrState.radioClkEn && pwrState.radioPowered) begin // R6
                    nxt_state = ST_ACTIVE;
                    nxt_exitIrq = 1'b1; // R6
                    nxt_actualDur = sleepCnt_ff; // R5
                end
            end
            default: begin
                nxt_state = ST_ACTIVE;
            end
        endcase
        // Scheduled window or external pulse drives the wake irq
        nxt_wakeIrq = ((state_ff == ST_SLEEP) && inWakeWindow && nxt_state == ST_SLEEP)
                   || (nxt_extCnt != '0); // R2
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= ST_ACTIVE;
            sleepCnt_ff <= 32'h0000_0000;
            extCnt_ff <= 8'h00;
            actualDur_ff <= 32'h0000_0000;
            wakeIrq_ff <= 1'b0;
            exitIrq_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sleepCnt_ff <= nxt_sleepCnt;
            extCnt_ff <= nxt_extCnt;
            actualDur_ff <= nxt_actualDur;
            wakeIrq_ff <= nxt_wakeIrq;
            exitIrq_ff <= nxt_exitIrq;
        end
    end

    assign lowpowerWakeInterrupt = wakeIrq_ff;
    assign sleepExitInterrupt = exitIrq_ff;

    // Diagnostic scheme select; any other code parks the port low
    always_comb begin
        nxt_diag = 8'h00; // R21
        if (diagSel1_ff == DIAG_CTRL_SEL && diagSel2_ff == DIAG_CTRL_SEL
                && diagSel3_ff == DIAG_ORDER_SEL) begin // R13
            nxt_diag = {bbSignals.errorIrq, // R17
                        bbSignals.rxIrq, // R18
                        bbSignals.eventIrq, // R18
                        bbSignals.eventActive,
                        bbSignals.syncFound && bbSignals.syncWindow, // R16
                        bbSignals.syncWindow,
                        bbSignals.rxEn,
                        bbSignals.txEn}; // R14
        end else if (diagSel1_ff == DIAG_DATA_SEL && diagSel2_ff == DIAG_DATA_SEL
                && diagSel3_ff == DIAG_ORDER_SEL) begin // R13
            nxt_diag = {bbSignals.txCoreDataEn,
                        bbSignals.txCoreData,
                        bbSignals.txDataEn,
                        bbSignals.txData,
                        bbSignals.rxCoreDataEn,
                        bbSignals.rxCoreData,
                        bbSignals.rxDataEn,
                        bbSignals.rxData}; // R15
        end
    end

    // One flop per pin keeps glitches off the pads
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            diag_ff <= 8'h00;
        end else begin
            diag_ff <= nxt_diag; // R12
        end
    end

    assign diagOut = diag_ff;

endmodule // rcsw_top
